// >>> hw/mbd_pkg.sv
package mbd_pkg;

   // ----------------------------------------------------------------
   // Instruction groups and per-instruction actions
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      CLS_OTHER, CLS_MOVE, CLS_CODE_LOAD, CLS_EXT_RD, CLS_EXT_WR, CLS_SWAP,
      CLS_JUMP, CLS_CALL, CLS_RETURN, CLS_COND, CLS_BIT, CLS_NOP
   } mbd_cls_t;

   typedef enum logic [4:0] {
      ACT_NONE, ACT_JMP, ACT_JZ, ACT_JNZ, ACT_JC, ACT_JNC, ACT_JB, ACT_JNB,
      ACT_JBC, ACT_COMPARE_JUMP_UNEQUAL, ACT_DJNZ, ACT_CLR_C, ACT_SET_C, ACT_CPL_C, ACT_ANL_C,
      ACT_ANL_NC, ACT_ORL_C, ACT_ORL_NC, ACT_MOV_C, ACT_MOV_BIT, ACT_CLR_BIT,
      ACT_SET_BIT, ACT_CPL_BIT
   } mbd_act_t;

   // ----------------------------------------------------------------
   // Lengths and cycle counts
   // ----------------------------------------------------------------
   localparam int CYC_W = 4;
   localparam logic [1:0] LEN_1 = 2'h1;
   localparam logic [1:0] LEN_2 = 2'h2;
   localparam logic [1:0] LEN_3 = 2'h3;
   localparam logic [CYC_W-1:0] CYC_0 = 4'h0;
   localparam logic [CYC_W-1:0] CYC_1 = 4'h1;
   localparam logic [CYC_W-1:0] CYC_2 = 4'h2;
   localparam logic [CYC_W-1:0] CYC_3 = 4'h3;
   localparam logic [CYC_W-1:0] CYC_4 = 4'h4;
   localparam logic [CYC_W-1:0] CYC_5 = 4'h5;
   localparam logic [CYC_W-1:0] CYC_6 = 4'h6;
   localparam logic [CYC_W-1:0] EXT_RD_BASE = CYC_3;
   localparam logic [CYC_W-1:0] EXT_WR_BASE = CYC_4;
   localparam int EXT_WAIT_W = 3;

   typedef struct packed {
      logic [1:0] len;
      logic [CYC_W-1:0] cyc;
      mbd_cls_t cls;
      mbd_act_t act;
   } mbd_dec_t;

   // ----------------------------------------------------------------
   // Status word layout and reset values
   // ----------------------------------------------------------------
   localparam int PSW_CY = 7;
   localparam int PSW_OV = 2;
   localparam int PSW_P = 0;
   localparam logic [7:0] PSW_RST = 8'h00;
   localparam mbd_dec_t DEC_RST = '{LEN_1, CYC_1, CLS_NOP, ACT_NONE};

endpackage

// >>> hw/mbd_dec_if.sv
`timescale 1ns/1ps
interface mbd_dec_if;
   import mbd_pkg::*;

   logic [7:0] opcode;
   mbd_dec_t dec;
   logic known;

   modport lut (input opcode, output dec, output known);
   modport core (output opcode, input dec, input known);
endinterface

// >>> hw/mbd_opcode_table.sv
`timescale 1ns/1ps
module mbd_opcode_table (
   mbd_dec_if.lut bus
);
   import mbd_pkg::*;

   // ----------------------------------------------------------------
   // Opcode lookup: length, base cycles, group, action
   // ----------------------------------------------------------------
   always_comb begin
      bus.known = 1'b1;
      bus.dec = '{LEN_1, CYC_1, CLS_OTHER, ACT_NONE};
      unique casez (bus.opcode)
         8'b1110_1???: bus.dec = '{LEN_1, CYC_1, CLS_MOVE, ACT_NONE};
         8'hE5, 8'h74: bus.dec = '{LEN_2, CYC_2, CLS_MOVE, ACT_NONE};
         8'hE6, 8'hE7: bus.dec = '{LEN_1, CYC_2, CLS_MOVE, ACT_NONE};
         8'b1111_1???: bus.dec = '{LEN_1, CYC_2, CLS_MOVE, ACT_NONE};
         8'b0111_1???: bus.dec = '{LEN_2, CYC_2, CLS_MOVE, ACT_NONE};
         8'b1010_1???: bus.dec = '{LEN_2, CYC_4, CLS_MOVE, ACT_NONE};
         8'hF5, 8'b1000_1???: bus.dec = '{LEN_2, CYC_3, CLS_MOVE, ACT_NONE};
         8'h85: bus.dec = '{LEN_3, CYC_4, CLS_MOVE, ACT_NONE};
         8'h86, 8'h87: bus.dec = '{LEN_2, CYC_4, CLS_MOVE, ACT_NONE};
         8'h75: bus.dec = '{LEN_3, CYC_3, CLS_MOVE, ACT_NONE};
         8'hF6, 8'hF7: bus.dec = '{LEN_1, CYC_3, CLS_MOVE, ACT_NONE};
         8'hA6, 8'hA7: bus.dec = '{LEN_2, CYC_5, CLS_MOVE, ACT_NONE};
         8'h76, 8'h77: bus.dec = '{LEN_2, CYC_3, CLS_MOVE, ACT_NONE};
         8'h90: bus.dec = '{LEN_3, CYC_3, CLS_MOVE, ACT_NONE};
         8'h93, 8'h83: bus.dec = '{LEN_1, CYC_3, CLS_CODE_LOAD, ACT_NONE};
         8'hE0, 8'hE2, 8'hE3: bus.dec = '{LEN_1, EXT_RD_BASE, CLS_EXT_RD, ACT_NONE};
         8'hF0, 8'hF2, 8'hF3: bus.dec = '{LEN_1, EXT_WR_BASE, CLS_EXT_WR, ACT_NONE};
         8'b1100_1???: bus.dec = '{LEN_1, CYC_2, CLS_SWAP, ACT_NONE};
         8'hC5: bus.dec = '{LEN_2, CYC_3, CLS_SWAP, ACT_NONE};
         8'hC6, 8'hC7, 8'hD6, 8'hD7: bus.dec = '{LEN_1, CYC_3, CLS_SWAP, ACT_NONE};
         8'b???1_0001: bus.dec = '{LEN_2, CYC_6, CLS_CALL, ACT_JMP};
         8'h12: bus.dec = '{LEN_3, CYC_6, CLS_CALL, ACT_JMP};
         8'h22, 8'h32: bus.dec = '{LEN_1, CYC_4, CLS_RETURN, ACT_JMP};
         8'b???0_0001: bus.dec = '{LEN_2, CYC_3, CLS_JUMP, ACT_JMP};
         8'h02: bus.dec = '{LEN_3, CYC_4, CLS_JUMP, ACT_JMP};
         8'h80: bus.dec = '{LEN_2, CYC_3, CLS_JUMP, ACT_JMP};
         8'h73: bus.dec = '{LEN_1, CYC_2, CLS_JUMP, ACT_JMP};
         8'h60: bus.dec = '{LEN_2, CYC_3, CLS_COND, ACT_JZ};
         8'h70: bus.dec = '{LEN_2, CYC_3, CLS_COND, ACT_JNZ};
         8'h40: bus.dec = '{LEN_2, CYC_3, CLS_COND, ACT_JC};
         8'h50: bus.dec = '{LEN_2, CYC_3, CLS_COND, ACT_JNC};
         8'h20: bus.dec = '{LEN_3, CYC_4, CLS_COND, ACT_JB};
         8'h30: bus.dec = '{LEN_3, CYC_4, CLS_COND, ACT_JNB};
         8'h10: bus.dec = '{LEN_3, CYC_4, CLS_COND, ACT_JBC};
         8'hB4, 8'b1011_1???: bus.dec = '{LEN_3, CYC_4, CLS_COND, ACT_COMPARE_JUMP_UNEQUAL};
         8'hB5, 8'hB6, 8'hB7: bus.dec = '{LEN_3, CYC_4, CLS_COND, ACT_COMPARE_JUMP_UNEQUAL};
         8'b1101_1???: bus.dec = '{LEN_2, CYC_3, CLS_COND, ACT_DJNZ};
         8'hD5: bus.dec = '{LEN_3, CYC_4, CLS_COND, ACT_DJNZ};
         8'h00: bus.dec = '{LEN_1, CYC_1, CLS_NOP, ACT_NONE};
         8'hC3: bus.dec = '{LEN_1, CYC_1, CLS_BIT, ACT_CLR_C};
         8'hD3: bus.dec = '{LEN_1, CYC_1, CLS_BIT, ACT_SET_C};
         8'hB3: bus.dec = '{LEN_1, CYC_1, CLS_BIT, ACT_CPL_C};
         8'hC2: bus.dec = '{LEN_2, CYC_3, CLS_BIT, ACT_CLR_BIT};
         8'hD2: bus.dec = '{LEN_2, CYC_3, CLS_BIT, ACT_SET_BIT};
         8'hB2: bus.dec = '{LEN_2, CYC_3, CLS_BIT, ACT_CPL_BIT};
         8'h82: bus.dec = '{LEN_2, CYC_2, CLS_BIT, ACT_ANL_C};
         8'hB0: bus.dec = '{LEN_2, CYC_2, CLS_BIT, ACT_ANL_NC};
         8'h72: bus.dec = '{LEN_2, CYC_2, CLS_BIT, ACT_ORL_C};
         8'hA0: bus.dec = '{LEN_2, CYC_2, CLS_BIT, ACT_ORL_NC};
         8'hA2: bus.dec = '{LEN_2, CYC_2, CLS_BIT, ACT_MOV_C};
         8'h92: bus.dec = '{LEN_2, CYC_3, CLS_BIT, ACT_MOV_BIT};
         // Arithmetic, logic and stack rows are not decoded here and report unknown
         default: bus.known = 1'b0;
      endcase
   end

endmodule

// >>> hw/mbd_cycle_counter.sv
`timescale 1ns/1ps
module mbd_cycle_counter #(
   parameter int W = 4
) (
   // Clock and reset
   input logic clk,
   input logic rst_n,
   // Control
   input logic load,
   input logic [W-1:0] load_val,
   // Count
   output logic [W-1:0] value
);

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   // ----------------------------------------------------------------
   // Down counter, parks at zero
   // ----------------------------------------------------------------
   always_comb begin
      cnt_nxt = cnt_r;
      if (load) begin
         cnt_nxt = load_val;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign value = cnt_r;

endmodule

// >>> hw/mbd_decoder.sv
// Summary of operation
// - Register to accumulator, one byte, one cycle
// - Accumulator loads direct, indirect, immediate: two cycles
// - Accumulator to register: one byte, two cycles
// - Immediate to register: two bytes, two cycles
// - Direct to direct: three bytes, four cycles
// - Indirect to direct: four cycles
// - Immediate to direct: three bytes, three cycles
// - Accumulator to indirect: three cycles
// - Direct to indirect: five cycles
// - Data pointer immediate load: three bytes, three cycles
// - Code byte loads take three cycles
// - External reads take three to ten cycles
// - External writes take four to eleven cycles
// - Mode bit selects external move action
// - Indirect swap and nibble swap: one byte, three cycles
// - Short jump three cycles, indirect jump two
// - Zero and non-zero jumps: two bytes, three cycles
// - Carry jumps: two bytes, three cycles
// - Bit test jump clears set bit: four cycles
// - Compare-jump-unequal immediate: three bytes, four cycles
// - Clear, set, complement bit: three cycles
// - Bit to carry two, carry to bit three
// - Carry, overflow, parity held in status word
`timescale 1ns/1ps
module mbd_decoder (
   // Clock and reset
   input logic CLK,
   input logic RSTN,
   // Instruction handshake
   input logic OPC_VALID,
   input logic [7:0] OPCODE,
   output logic READY,
   output logic BUSY,
   output logic DONE,
   // Decoded instruction
   output logic [1:0] INSTR_LEN,
   output logic [mbd_pkg::CYC_W-1:0] INSTR_CYCLES,
   output mbd_pkg::mbd_cls_t INSTR_CLASS,
   output logic INSTR_KNOWN,
   // External memory moves
   input logic [mbd_pkg::EXT_WAIT_W-1:0] EXT_WAIT,
   input logic PMW,
   output logic EXT_CODE_SPACE,
   // Operand conditions from the datapath
   input logic [7:0] ACC,
   input logic BIT_VAL,
   input logic CMP_NE,
   input logic CMP_LT,
   input logic DEC_ZERO,
   // Branch and bit results
   output logic BRANCH_VALID,
   output logic BRANCH_TAKEN,
   output logic BIT_WE,
   output logic BIT_WDATA,
   // Status word
   input logic PSW_WE,
   input logic [7:0] PSW_WDATA,
   output logic [7:0] PROGRAM_STATUS_WORD
);
   import mbd_pkg::*;

   typedef enum logic {ST_IDLE, ST_EXEC} mbd_state_t;

   // ----------------------------------------------------------------
   // Opcode lookup and cycle counter
   // ----------------------------------------------------------------
   mbd_dec_if dec_bus ();

   logic [CYC_W-1:0] cnt;
   logic [CYC_W-1:0] start_cyc;
   logic accept;
   logic done;
   logic is_ext;

   assign dec_bus.opcode = OPCODE;

   mbd_opcode_table u_table (
      .bus (dec_bus.lut)
   );

   mbd_cycle_counter #(
      .W (CYC_W)
   ) u_count (
      .clk (CLK),
      .rst_n (RSTN),
      .load (accept),
      .load_val (start_cyc),
      .value (cnt)
   );

   // Wait states stretch only the external moves
   assign is_ext = (dec_bus.dec.cls == CLS_EXT_RD) || (dec_bus.dec.cls == CLS_EXT_WR);
   assign start_cyc = is_ext ? dec_bus.dec.cyc + CYC_W'(EXT_WAIT)
                             : dec_bus.dec.cyc;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   mbd_state_t state_r;
   mbd_state_t state_nxt;

   // Ready in the last cycle lets instructions run back to back
   assign done = (state_r == ST_EXEC) && (cnt == CYC_1);
   assign READY = (state_r == ST_IDLE) || done;
   assign accept = OPC_VALID && READY;
   assign BUSY = (state_r == ST_EXEC);
   assign DONE = done;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (accept) begin
               state_nxt = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (done && !accept) begin
               state_nxt = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Latched decode of the running instruction
   // ----------------------------------------------------------------
   mbd_dec_t cur_r;
   mbd_dec_t cur_nxt;
   logic known_r;
   logic known_nxt;
   logic ext_space_r;
   logic ext_space_nxt;

   always_comb begin
      cur_nxt = cur_r;
      known_nxt = known_r;
      ext_space_nxt = ext_space_r;
      if (accept) begin
         cur_nxt = dec_bus.dec;
         cur_nxt.cyc = start_cyc;
         known_nxt = dec_bus.known;
         // Mode sampled at issue so a mid-move change cannot split it
         if (is_ext) begin
            ext_space_nxt = PMW;
         end
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         cur_r <= DEC_RST;
         known_r <= 1'b1;
         ext_space_r <= 1'b0;
      end else begin
         cur_r <= cur_nxt;
         known_r <= known_nxt;
         ext_space_r <= ext_space_nxt;
      end
   end

   assign INSTR_LEN = cur_r.len;
   assign INSTR_CYCLES = cur_r.cyc;
   assign INSTR_CLASS = cur_r.cls;
   assign INSTR_KNOWN = known_r;
   assign EXT_CODE_SPACE = ext_space_r;

   // ----------------------------------------------------------------
   // Branch outcome, bit writes and status word
   // ----------------------------------------------------------------
   logic taken_r;
   logic taken_nxt;
   logic bvalid_r;
   logic bvalid_nxt;
   logic bit_we_r;
   logic bit_we_nxt;
   logic bit_wd_r;
   logic bit_wd_nxt;
   logic [7:0] psw_r;
   logic [7:0] psw_nxt;
   logic cy;
   logic acc_zero;

   assign cy = psw_r[PSW_CY];
   assign acc_zero = (ACC == 8'h00);

   always_comb begin
      taken_nxt = 1'b0;
      bit_we_nxt = 1'b0;
      bit_wd_nxt = 1'b0;
      bvalid_nxt = done && (cur_r.cls inside {CLS_JUMP, CLS_CALL, CLS_RETURN, CLS_COND});
      psw_nxt = PSW_WE ? PSW_WDATA : psw_r;
      psw_nxt[PSW_P] = ^ACC;
      // Hardware carry update wins over a same-cycle software write
      if (done) begin
         unique case (cur_r.act)
            ACT_NONE: taken_nxt = 1'b0;
            ACT_JMP: taken_nxt = 1'b1;
            ACT_JZ: taken_nxt = acc_zero;
            ACT_JNZ: taken_nxt = !acc_zero;
            ACT_JC: taken_nxt = cy;
            ACT_JNC: taken_nxt = !cy;
            ACT_JB: taken_nxt = BIT_VAL;
            ACT_JNB: taken_nxt = !BIT_VAL;
            ACT_JBC: begin
               taken_nxt = BIT_VAL;
               bit_we_nxt = BIT_VAL;
            end
            ACT_COMPARE_JUMP_UNEQUAL: begin
               taken_nxt = CMP_NE;
               psw_nxt[PSW_CY] = CMP_LT;
            end
            ACT_DJNZ: taken_nxt = !DEC_ZERO;
            ACT_CLR_C: psw_nxt[PSW_CY] = 1'b0;
            ACT_SET_C: psw_nxt[PSW_CY] = 1'b1;
            ACT_CPL_C: psw_nxt[PSW_CY] = !cy;
            ACT_ANL_C: psw_nxt[PSW_CY] = cy & BIT_VAL;
            ACT_ANL_NC: psw_nxt[PSW_CY] = cy & !BIT_VAL;
            ACT_ORL_C: psw_nxt[PSW_CY] = cy | BIT_VAL;
            ACT_ORL_NC: psw_nxt[PSW_CY] = cy | !BIT_VAL;
            ACT_MOV_C: psw_nxt[PSW_CY] = BIT_VAL;
            ACT_MOV_BIT: begin
               bit_we_nxt = 1'b1;
               bit_wd_nxt = cy;
            end
            ACT_CLR_BIT: bit_we_nxt = 1'b1;
            ACT_SET_BIT: begin
               bit_we_nxt = 1'b1;
               bit_wd_nxt = 1'b1;
            end
            ACT_CPL_BIT: begin
               bit_we_nxt = 1'b1;
               bit_wd_nxt = !BIT_VAL;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         taken_r <= 1'b0;
         bvalid_r <= 1'b0;
         bit_we_r <= 1'b0;
         bit_wd_r <= 1'b0;
         psw_r <= PSW_RST;
      end else begin
         taken_r <= taken_nxt;
         bvalid_r <= bvalid_nxt;
         bit_we_r <= bit_we_nxt;
         bit_wd_r <= bit_wd_nxt;
         psw_r <= psw_nxt;
      end
   end

   assign BRANCH_VALID = bvalid_r;
   assign BRANCH_TAKEN = taken_r;
   assign BIT_WE = bit_we_r;
   assign BIT_WDATA = bit_wd_r;
   assign PROGRAM_STATUS_WORD = psw_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   logic [CYC_W-1:0] el_r;
   logic [CYC_W-1:0] el_nxt;

   always_comb begin
      el_nxt = el_r;
      if (accept) begin
         el_nxt = CYC_1;
      end else if (BUSY) begin
         el_nxt = el_r + CYC_1;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         el_r <= CYC_0;
      end else begin
         el_r <= el_nxt;
      end
   end
   sequence s_done_2;
      !DONE ##1 DONE;
   endsequence
   sequence s_done_4;
      !DONE [*3] ##1 DONE;
   endsequence
   sequence s_done_5;
      !DONE [*4] ##1 DONE;
   endsequence

   mov_a_rn_a: assert property (
      accept && (OPCODE[7:3] == 5'h1D) |=> DONE && (INSTR_LEN == LEN_1))
      else $error("register to accumulator not one cycle");
   acc_load_a: assert property (
      accept && (OPCODE inside {8'hE5, 8'hE6, 8'hE7, 8'h74}) |=> s_done_2)
      else $error("accumulator load not two cycles");
   dir_dir_a: assert property (
      accept && (OPCODE == 8'h85) |=> (INSTR_LEN == LEN_3) ##0 s_done_4)
      else $error("direct to direct length or timing wrong");
   dir_to_ind_a: assert property (
      accept && (OPCODE inside {8'hA6, 8'hA7}) |=> s_done_5)
      else $error("direct to indirect not five cycles");
   ext_rd_cyc_a: assert property (
      accept && (OPCODE inside {8'hE0, 8'hE2, 8'hE3})
      |=> INSTR_CYCLES == EXT_RD_BASE + CYC_W'($past(EXT_WAIT)))
      else $error("external read cycle count wrong");
   ext_mode_a: assert property (
      accept && is_ext |=> EXT_CODE_SPACE == $past(PMW))
      else $error("external move mode not latched");
   cycle_count_a: assert property (
      DONE |-> el_r == INSTR_CYCLES)
      else $error("instruction ended at wrong cycle");
   jz_take_a: assert property (
      DONE && (cur_r.act == ACT_JZ) |=> BRANCH_VALID && (BRANCH_TAKEN == $past(acc_zero)))
      else $error("zero jump decision wrong");
   bit_clear_a: assert property (
      DONE && (cur_r.act == ACT_JBC) && BIT_VAL |=> BIT_WE && !BIT_WDATA && BRANCH_TAKEN)
      else $error("bit test jump did not clear bit");
   carry_load_a: assert property (
      DONE && (cur_r.act == ACT_MOV_C) |=> PROGRAM_STATUS_WORD[PSW_CY] == $past(BIT_VAL))
      else $error("bit to carry copy wrong");
   parity_a: assert property (
      1'b1 |=> PROGRAM_STATUS_WORD[PSW_P] == $past(^ACC))
      else $error("parity flag does not follow accumulator");
endmodule

// >>> test/mbd_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Program memory and external memory stand-in
// ----------------------------------------------------------------
module mbd_mem_model (
   // Fetch
   input wire logic [5:0] addr,
   output logic [7:0] code_byte,
   // External memory speed
   input wire logic slow,
   output logic [2:0] ext_wait
);
   localparam logic [7:0] ROM [0:39] = '{
      8'hE8, 8'hE5, 8'hE6, 8'h74, 8'hF8, 8'h78, 8'h85, 8'h86, 8'h75, 8'hF6,
      8'hA6, 8'h90, 8'h93, 8'h83, 8'hC6, 8'hD6, 8'h80, 8'h73, 8'h60, 8'h70,
      8'h40, 8'h50, 8'h10, 8'hB4, 8'hB8, 8'hC2, 8'hD2, 8'hB2, 8'hA2, 8'h92,
      8'h12, 8'h24, 8'hE0, 8'hE2, 8'hF0, 8'hF2,
      8'hD8, 8'h20, 8'hD3, 8'hC3};
   assign code_byte = ROM[addr];
   // Slowest part uses every wait state the core can add
   assign ext_wait = slow ? 3'h7 : 3'h0;
endmodule

// >>> test/mbd_decoder_test.sv
`timescale 1ns/1ps
module mbd_decoder_test;
   import mbd_pkg::*;
   // Length in high nibble, cycles in low nibble, per code slot
   localparam logic [7:0] EXP [0:31] = '{
      8'h11, 8'h22, 8'h12, 8'h22, 8'h12, 8'h22, 8'h34, 8'h24, 8'h33, 8'h13,
      8'h25, 8'h33, 8'h13, 8'h13, 8'h13, 8'h13, 8'h23, 8'h12, 8'h23, 8'h23,
      8'h23, 8'h23, 8'h34, 8'h34, 8'h34, 8'h23, 8'h23, 8'h23, 8'h22, 8'h23,
      8'h36, 8'h11};
   logic clk = 1'b0, rstn = 1'b0, opc_valid = 1'b0, pmw = 1'b0, slow = 1'b0;
   logic bit_val = 1'b0, cmp_ne = 1'b0, cmp_lt = 1'b0, psw_we = 1'b0, dec_zero = 1'b0;
   logic [7:0] acc = 8'h00, psw_wdata = 8'h00, opcode, program_status_word;
   logic [5:0] pc = 6'h00;
   logic [2:0] ext_wait;
   logic ready, busy, done, known, ext_code, br_valid, br_taken, bit_we, bit_wdata;
   logic [1:0] len;
   logic [CYC_W-1:0] cycles;
   mbd_cls_t cls;
   int fail_count = 0, comparisons = 0, tick_count = 0, n;

   mbd_mem_model u_mem (.addr(pc), .code_byte(opcode), .slow(slow), .ext_wait(ext_wait));
   mbd_decoder u_dut (.CLK(clk), .RSTN(rstn), .OPC_VALID(opc_valid), .OPCODE(opcode),
      .READY(ready), .BUSY(busy), .DONE(done), .INSTR_LEN(len), .INSTR_CYCLES(cycles),
      .INSTR_CLASS(cls), .INSTR_KNOWN(known), .EXT_WAIT(ext_wait), .PMW(pmw),
      .EXT_CODE_SPACE(ext_code), .ACC(acc), .BIT_VAL(bit_val), .CMP_NE(cmp_ne),
      .CMP_LT(cmp_lt), .DEC_ZERO(dec_zero), .BRANCH_VALID(br_valid), .BRANCH_TAKEN(br_taken),
      .BIT_WE(bit_we), .BIT_WDATA(bit_wdata), .PSW_WE(psw_we), .PSW_WDATA(psw_wdata),
      .PROGRAM_STATUS_WORD(program_status_word));

   initial begin
      forever #20 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Reporting
   // ----------------------------------------------------------------
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   // Longest path through the tests is well under this
   always @(posedge clk) begin
      tick_count++;
      if (tick_count == 4000) begin
         fail_count++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------
   // Instruction driver: returns in the completion cycle
   // ----------------------------------------------------------------
   task automatic tick;
      @(posedge clk);
      #1;
   endtask

   task automatic run_op(input logic [5:0] idx);
      pc = idx;
      opc_valid = 1'b1;
      while (ready !== 1'b1) tick();
      tick();
      // One-cycle op: strobe stays up, caller chains or drops it
      if (done !== 1'b1) begin
         opc_valid = 1'b0;
      end
      n = 1;
      while (done !== 1'b1 && n < 20) begin
         tick();
         n++;
      end
   endtask

   // Result flags one cycle after completion
   task automatic chk_branch(input logic taken);
      tick();
      chk({7'h00, br_valid}, 8'h01);
      chk({7'h00, br_taken}, {7'h00, taken});
   endtask

   task automatic chk_bit(input logic val);
      tick();
      chk({7'h00, bit_we}, 8'h01);
      chk({7'h00, bit_wdata}, {7'h00, val});
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_table;
      // Back to back: each accept after the first lands in the previous completion cycle
      for (int i = 0; i < 32; i++) begin
         run_op(i[5:0]);
         chk(n[7:0], {4'h0, EXP[i][3:0]});
         chk({6'h00, len}, {4'h0, EXP[i][7:4]});
         chk({4'h0, cycles}, {4'h0, EXP[i][3:0]});
         chk({7'h00, known}, {7'h00, i != 31});
         chk({7'h00, busy}, 8'h01);
      end
      opc_valid = 1'b0;
      tick();
      chk({7'h00, busy}, 8'h00);
      $display("test table done");
   endtask

   task automatic t_ext;
      for (int w = 0; w < 2; w++) begin
         slow = w[0];
         pmw = w[0];
         for (int k = 32; k < 36; k++) begin
            run_op(k[5:0]);
            chk(n[7:0], 8'((k < 34 ? 3 : 4) + 7 * w));
            chk({7'h00, ext_code}, {7'h00, pmw});
            chk({4'h0, cls}, {4'h0, (k < 34) ? CLS_EXT_RD : CLS_EXT_WR});
         end
      end
      tick();
      $display("test ext done");
   endtask

   task automatic t_branch;
      acc = 8'h00;
      run_op(6'd18);
      chk_branch(1'b1);
      acc = 8'h07;
      run_op(6'd18);
      chk_branch(1'b0);
      run_op(6'd19);
      chk_branch(1'b1);
      psw_we = 1'b1;
      psw_wdata = 8'h84;
      tick();
      psw_we = 1'b0;
      tick();
      chk(program_status_word, 8'h85);
      run_op(6'd20);
      chk_branch(1'b1);
      run_op(6'd21);
      chk_branch(1'b0);
      bit_val = 1'b1;
      run_op(6'd22);
      chk_branch(1'b1);
      chk({6'h00, bit_we, bit_wdata}, 8'h02);
      cmp_ne = 1'b1;
      run_op(6'd23);
      chk_branch(1'b1);
      chk({7'h00, program_status_word[PSW_CY]}, 8'h00);
      dec_zero = 1'b1;
      run_op(6'd36);
      chk_branch(1'b0);
      run_op(6'd37);
      chk_branch(1'b1);
      $display("test branch done");
   endtask

   task automatic t_bits;
      run_op(6'd25);
      chk_bit(1'b0);
      run_op(6'd26);
      chk_bit(1'b1);
      run_op(6'd27);
      chk_bit(1'b0);
      run_op(6'd28);
      tick();
      chk({7'h00, program_status_word[PSW_CY]}, 8'h01);
      run_op(6'd29);
      chk_bit(1'b1);
      run_op(6'd39);
      opc_valid = 1'b0;
      tick();
      chk({7'h00, program_status_word[PSW_CY]}, 8'h00);
      run_op(6'd38);
      opc_valid = 1'b0;
      tick();
      chk({7'h00, program_status_word[PSW_CY]}, 8'h01);
      $display("test bits done");
   endtask

   initial begin
      repeat (3) @(posedge clk);
      #1;
      rstn = 1'b1;
      chk({6'h00, len}, 8'h01);
      chk(program_status_word, 8'h00);
      t_table();
      t_ext();
      t_branch();
      t_bits();
      give_verdict();
   end
endmodule
